// File: rtl/jaf_device.sv
// elastic store jitter attenuator: 16-bit fifo, steered oscillator, flags
// assumes link pins are asynchronous to i_mclk and are synchronised here
//
// What this block does
// - flag clear low returns error flag low
// - pointer reset low reinitialises both pointers
// - monitor output off during pointer reset
// - select low: oscillator reads and makes clock
// - select high: alternate clock advances read pointer
// - input bit captured on input clock fall
// - alternate mode: output clock follows alternate clock
// - flag high on overflow/underflow, sticky
// - data out stable at output clock rise
// - monitor output is oscillator divided four
// - no input clock: steer toward an end
// - read overtaking write is an error
// - absorb at least seven unit intervals
// - centred oscillator keeps pointers half apart
// - slaves select alternate, share pointer reset
// - system pulses pointer reset after startup
// - system then pulses flag clear
// - slave clock from master or preceding
// - reset pointers to first and eighth
// - oscillator runs, output clock low
// - slip loses sixteen bits, then relocks
// - periodic update holds fifo half full
`timescale 1ns/1ps
module jaf_device (
  input wire logic i_mclk,
  input wire logic i_reset,
  jaf_link_if.device link,
  output logic o_output_clock,
  output logic o_slip_error_flag,
  output logic [jaf_pkg::STEP_W-1:0] o_osc_step
);
  import jaf_pkg::*;
  // three-stage synchronisers; a change counts when stages two and three agree
  logic [2:0] ck_s, dt_s, ac_s, sel_s, pr_s, fc_s;
  logic ck_f, ac_f, sel_f, pr_f, fc_f;
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ck_s <= 3'h0; dt_s <= 3'h0; ac_s <= 3'h0;
      sel_s <= 3'h0; pr_s <= 3'h0; fc_s <= 3'h7;
    end else begin
      ck_s <= {ck_s[1:0], link.input_clock};
      dt_s <= {dt_s[1:0], link.data_in};
      ac_s <= {ac_s[1:0], link.alternate_read_clock};
      sel_s <= {sel_s[1:0], link.read_source_alt};
      pr_s <= {pr_s[1:0], link.pointer_reset_n};
      fc_s <= {fc_s[1:0], link.flag_clear_n};
    end
  end
  // filtered levels: update only when stages two and three agree
  // so a pin that settles again within one clock is never seen as an edge
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ck_f <= 1'b0; ac_f <= 1'b0; sel_f <= 1'b0; pr_f <= 1'b0; fc_f <= 1'b1;
    end else begin
      if (ck_s[1] == ck_s[2]) ck_f <= ck_s[2];
      if (ac_s[1] == ac_s[2]) ac_f <= ac_s[2];
      if (sel_s[1] == sel_s[2]) sel_f <= sel_s[2];
      if (pr_s[1] == pr_s[2]) pr_f <= pr_s[2];
      if (fc_s[1] == fc_s[2]) fc_f <= fc_s[2];
    end
  end
  logic ck_last_q, ac_last_q;
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ck_last_q <= 1'b0;
      ac_last_q <= 1'b0;
    end else begin
      ck_last_q <= ck_f;
      ac_last_q <= ac_f;
    end
  end
  wire wr_fall = ck_last_q && !ck_f;
  wire ac_rise = !ac_last_q && ac_f;
  wire ac_fall = ac_last_q && !ac_f;
  wire ptr_rst = !pr_f;
  // steered oscillator: period shrinks as the step rises; runs through pointer reset
  // limitation: the five steps bound the range of input rates that can be tracked
  logic [7:0] osc_cnt_q;
  logic osc_tick_q;
  logic [2:0] step_q;
  wire [7:0] osc_period = BASE_PERIOD - {5'h00, step_q};
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      osc_cnt_q <= 8'h00;
      osc_tick_q <= 1'b0;
    end else if (osc_cnt_q >= osc_period) begin
      osc_cnt_q <= 8'h00;
      osc_tick_q <= 1'b1;
    end else begin
      osc_cnt_q <= osc_cnt_q + 8'h01;
      osc_tick_q <= 1'b0;
    end
  end
  // divide by four: two ticks per half period of the read clock
  logic [1:0] div_q;
  logic osc_clk_q;
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      div_q <= 2'h0;
      osc_clk_q <= 1'b0;
    end else if (osc_tick_q) begin
      div_q <= div_q + 2'h1;
      if (div_q[0]) osc_clk_q <= ~osc_clk_q;
    end
  end
  logic osc_last_q;
  always_ff @(posedge i_mclk) begin
    if (i_reset) osc_last_q <= 1'b0;
    else osc_last_q <= osc_clk_q;
  end
  wire osc_rise = !osc_last_q && osc_clk_q;
  wire osc_fall = osc_last_q && !osc_clk_q;
  // read source select; alternate source in slave role
  wire rd_rise = sel_f ? ac_rise : osc_rise;
  wire rd_fall = sel_f ? ac_fall : osc_fall;
  // fifo storage and pointers
  logic [DEPTH-1:0] mem_q;
  logic [3:0] wr_q, rd_q;
  logic [4:0] bad_q;
  logic dout_q, oclk_q, mon_q, flag_q;
  wire [3:0] sep = jaf_sep(wr_q, rd_q);
  // write side: a full ring with one more write is overflow; read meeting write underflows
  // equal pointers mean empty, so the ring holds at most fifteen unread bits
  wire ovf = wr_fall && (jaf_sep(wr_q + 4'h1, rd_q) == 4'h0);
  wire unf = rd_fall && (sep == 4'h0);
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      mem_q <= '0;
    end else if (wr_fall && !ptr_rst) begin
      mem_q[wr_q] <= dt_s[2];
    end
  end
  // pointer reset and slips both put the pointers back to first and eighth, nine unread bits apart
  always_ff @(posedge i_mclk) begin
    if (i_reset || ptr_rst) begin
      wr_q <= WR_RESET_PTR;
      rd_q <= RD_RESET_PTR;
    end else if (ovf || unf) begin
      wr_q <= WR_RESET_PTR; // slip drops held bits and recentres
      rd_q <= RD_RESET_PTR;
    end else begin
      if (wr_fall) wr_q <= wr_q + 4'h1;
      if (rd_fall) rd_q <= rd_q + 4'h1;
    end
  end
  // after underflow the next sixteen bits read are counted as invalid
  always_ff @(posedge i_mclk) begin
    if (i_reset || ptr_rst) bad_q <= 5'h00;
    else if (unf) bad_q <= INVALID_BITS;
    else if (rd_fall && bad_q != 5'h00) bad_q <= bad_q - 5'h01;
  end
  // data changes on the falling read edge so it is settled at the rise
  // bits read while the invalid count runs are forced low, so stale ring
  // contents after an underflow never pass as fresh data
  always_ff @(posedge i_mclk) begin
    if (i_reset || ptr_rst) dout_q <= 1'b0;
    else if (rd_fall && bad_q != 5'h00) dout_q <= 1'b0;
    else if (rd_fall) dout_q <= mem_q[rd_q];
  end
  // output clock: oscillator or alternate clock, low during pointer reset
  always_ff @(posedge i_mclk) begin
    if (i_reset || ptr_rst) oclk_q <= 1'b0;
    else if (sel_f) oclk_q <= ac_f;
    else oclk_q <= osc_clk_q;
  end
  always_ff @(posedge i_mclk) begin
    if (i_reset || ptr_rst) mon_q <= 1'b0;
    else mon_q <= osc_clk_q;
  end
  // sticky slip flag; a slip in the clear cycle still sets it
  always_ff @(posedge i_mclk) begin
    if (i_reset) flag_q <= 1'b0;
    else if (ovf || unf) flag_q <= 1'b1;
    else if (!fc_f) flag_q <= 1'b0;
  end
  // periodic steering toward half full; no input clock drifts the step to one end
  // while a reversed pointer relation after reset drifts it to the other
  // one step per update keeps the loop slow, so jitter is absorbed, not tracked
  logic [9:0] upd_q;
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      upd_q <= 10'h000;
      step_q <= STEP_MID;
    end else if (ptr_rst) begin
      upd_q <= 10'h000; // oscillator keeps its last setting
    end else if (upd_q == UPDATE_TICKS) begin
      upd_q <= 10'h000;
      // half separation gives full margin both ways
      // free room ahead of the write pointer below half: read faster, and the
      // other way round; sep counts unread bits, so the room is what sep leaves
      if (sep > HALF_SEP && step_q != STEP_MAX) begin
        step_q <= step_q + 3'h1;
      end else if (sep < HALF_SEP && step_q != STEP_MIN) begin
        step_q <= step_q - 3'h1;
      end
    end else begin
      upd_q <= upd_q + 10'h001;
    end
  end
  assign link.output_clock = oclk_q;
  assign link.data_out = dout_q;
  assign link.slip_error_flag = flag_q;
  assign link.oscillator_monitor_out = mon_q;
  assign o_output_clock = oclk_q;
  assign o_slip_error_flag = flag_q;
  assign o_osc_step = step_q;
endmodule

// File: rtl/jaf_pkg.sv
// constants shared by the jitter attenuator fifo and its line-side source
// assumes one system clock i_mclk at 125 MHz; link clocks are sampled as pins
package jaf_pkg;
  localparam int unsigned DEPTH = 16;
  localparam int unsigned PTR_W = 4;
  localparam logic [3:0] WR_RESET_PTR = 4'h0;
  localparam logic [3:0] RD_RESET_PTR = 4'h7;
  localparam logic [3:0] HALF_SEP = 4'h8;
  localparam int unsigned OSC_DIV = 4;
  localparam logic [1:0] OSC_DIV_LAST = 2'h3;
  localparam int unsigned STEP_W = 3;
  localparam logic [2:0] STEP_MIN = 3'h0;
  localparam logic [2:0] STEP_MID = 3'h2;
  localparam logic [2:0] STEP_MAX = 3'h4;
  localparam logic [7:0] BASE_PERIOD = 8'h14;
  localparam logic [9:0] UPDATE_TICKS = 10'h3ff;
  localparam logic [7:0] SRC_HALF_PERIOD = 8'h28;
  localparam logic [4:0] INVALID_BITS = 5'h10;
  function automatic logic [3:0] jaf_sep(input logic [3:0] wr, input logic [3:0] rd);
    jaf_sep = wr - rd;
  endfunction
endpackage

// File: rtl/jaf_link_if.sv
// pins between line-side source and elastic fifo device
// assumes both ends run on the same i_mclk; clocks here are plain pin levels
`timescale 1ns/1ps
interface jaf_link_if;
  logic input_clock;
  logic data_in;
  logic alternate_read_clock;
  logic read_source_alt;
  logic pointer_reset_n;
  logic flag_clear_n;
  logic output_clock;
  logic data_out;
  logic slip_error_flag;
  logic oscillator_monitor_out;
  modport device (
    input input_clock, data_in, alternate_read_clock, read_source_alt,
    input pointer_reset_n, flag_clear_n,
    output output_clock, data_out, slip_error_flag, oscillator_monitor_out
  );
  modport source (
    output input_clock, data_in, alternate_read_clock, read_source_alt,
    output pointer_reset_n, flag_clear_n,
    input output_clock, data_out, slip_error_flag, oscillator_monitor_out
  );
endinterface

// File: rtl/jaf_source.sv
// line-side party: makes input_clock and data, runs the startup reset sequence
// assumes i_mclk; user gives bits through a valid/ready pair
`timescale 1ns/1ps
module jaf_source (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_bit,
  input wire logic i_bit_valid,
  output logic o_bit_ready,
  input wire logic i_use_alt,
  input wire logic i_alt_clock,
  jaf_link_if.source link
);
  import jaf_pkg::*;
  typedef enum logic [3:0] {
    SQ_PTR = 4'b0001, SQ_GAP = 4'b0010, SQ_CLR = 4'b0100, SQ_RUN = 4'b1000
  } jaf_seq_t;
  jaf_seq_t seq_q;
  logic [7:0] div_q;
  logic clk_q;
  logic [3:0] cnt_q;
  logic dat_q;
  logic ready_q;
  // divider for input_clock; the pointer reset starts together with the clock, straight out of reset
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      div_q <= 8'h00;
      clk_q <= 1'b0;
    end else if (div_q == SRC_HALF_PERIOD) begin
      div_q <= 8'h00;
      clk_q <= ~clk_q;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end
  // new data on rising edge so it is settled for the device's falling edge
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      dat_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      ready_q <= (div_q == SRC_HALF_PERIOD) && !clk_q;
      if (ready_q && i_bit_valid) begin
        dat_q <= i_bit;
      end
    end
  end
  // pointer reset pulse, then flag clear pulse
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      seq_q <= SQ_PTR;
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      case (seq_q)
        SQ_PTR: if (cnt_q == 4'hf) seq_q <= SQ_GAP;
        SQ_GAP: if (cnt_q == 4'hf) seq_q <= SQ_CLR;
        SQ_CLR: if (cnt_q == 4'hf) seq_q <= SQ_RUN;
        SQ_RUN: cnt_q <= 4'h0;
        default: seq_q <= SQ_PTR;
      endcase
    end
  end
  assign o_bit_ready = ready_q;
  assign link.input_clock = clk_q;
  assign link.data_in = dat_q;
  assign link.read_source_alt = i_use_alt; // slave: tie high, feed master clock
  assign link.alternate_read_clock = i_alt_clock; // master or preceding slave
  assign link.pointer_reset_n = (seq_q != SQ_PTR); // shared by all cascaded parts
  assign link.flag_clear_n = (seq_q != SQ_CLR);
endmodule

// File: test/jaf_properties.sv
// checker on the link pins between source and elastic fifo
// assumes one clock i_mclk and a synchronous active-high i_reset
`timescale 1ns/1ps
module jaf_properties (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic pointer_reset_n,
  input wire logic flag_clear_n,
  input wire logic read_source_alt,
  input wire logic alternate_read_clock,
  input wire logic output_clock,
  input wire logic data_out,
  input wire logic slip_error_flag,
  input wire logic oscillator_monitor_out,
  input wire logic [jaf_pkg::STEP_W-1:0] o_osc_step
);
  import jaf_pkg::*;
  logic [9:0] flag_age_q;
  logic [9:0] clr_age_q;
  logic [9:0] mon_age_q;
  logic mon_prev_q;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  // saturating ages; monitor age skips alt mode, though the osc keeps running there
  always_ff @(posedge i_mclk) begin
    flag_age_q <= (i_reset || !slip_error_flag) ? 10'h0 : flag_age_q + 10'(!(&flag_age_q));
    clr_age_q <= (i_reset || !flag_clear_n) ? 10'h0 : clr_age_q + 10'(!(&clr_age_q));
    mon_prev_q <= oscillator_monitor_out;
    if (i_reset || !pointer_reset_n || read_source_alt ||
        mon_prev_q != oscillator_monitor_out) begin
      mon_age_q <= 10'h0;
    end else begin
      mon_age_q <= mon_age_q + 10'(!(&mon_age_q));
    end
  end
  AST_MON_OFF: assert property ((!pointer_reset_n) [*8] |-> !oscillator_monitor_out)
    else $error("monitor active in pointer reset");
  AST_CLK_LOW: assert property ((!pointer_reset_n) [*8] |-> !output_clock)
    else $error("output clock high in pointer reset");
  AST_ALT_FOLLOW: assert property ((read_source_alt && pointer_reset_n &&
    $stable(alternate_read_clock)) [*8] |-> output_clock == alternate_read_clock)
    else $error("output clock not following alternate clock");
  AST_FLAG_STICKY: assert property ($fell(slip_error_flag) |-> clr_age_q < 10'h8)
    else $error("flag dropped without clear");
  AST_FLAG_CLEAR: assert property ((!flag_clear_n) [*8] |-> flag_age_q < 10'h8)
    else $error("flag not cleared");
  AST_DOUT_STABLE: assert property ($rose(output_clock) |-> $stable(data_out))
    else $error("data out moved at clock rise");
  AST_STEP_RANGE: assert property (o_osc_step inside {[STEP_MIN:STEP_MAX]})
    else $error("step out of range");
  AST_STEP_ONE: assert property ($changed(o_osc_step) |->
    (o_osc_step - $past(o_osc_step) == 3'h1) || ($past(o_osc_step) - o_osc_step == 3'h1))
    else $error("step jumped");
  AST_STEP_HOLD: assert property ($changed(o_osc_step) |=> $stable(o_osc_step) [*8])
    else $error("step updated too often");
  AST_MON_RUNS: assert property (mon_age_q < 10'h190)
    else $error("monitor output stalled");
endmodule

// File: test/jaf_bench.sv
// self-checking bench: source and device joined by the link interface
// assumes i_mclk at 125 MHz; inputs change on the falling edge
`timescale 1ns/1ps
module jaf_bench;
  import jaf_pkg::*;
  logic i_mclk, dev_reset, src_reset, bit_in, use_alt, alt_clk, alt_run;
  logic o_output_clock, o_slip_error_flag;
  logic [STEP_W-1:0] o_osc_step;
  int fails, total_checks, alt_cnt, alt_half;
  jaf_link_if link ();
  jaf_source u_jaf_source (.i_mclk(i_mclk), .i_reset(src_reset), .i_bit(bit_in),
    .i_bit_valid(1'b1), .o_bit_ready(), .i_use_alt(use_alt), .i_alt_clock(alt_clk), .link(link));
  jaf_device u_jaf_device (.i_mclk(i_mclk), .i_reset(dev_reset), .link(link),
    .o_output_clock(o_output_clock), .o_slip_error_flag(o_slip_error_flag),
    .o_osc_step(o_osc_step));
  jaf_properties u_jaf_properties (.i_mclk(i_mclk), .i_reset(dev_reset),
    .pointer_reset_n(link.pointer_reset_n), .flag_clear_n(link.flag_clear_n),
    .read_source_alt(link.read_source_alt), .alternate_read_clock(link.alternate_read_clock),
    .output_clock(link.output_clock), .data_out(link.data_out),
    .slip_error_flag(link.slip_error_flag),
    .oscillator_monitor_out(link.oscillator_monitor_out), .o_osc_step(o_osc_step));
  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end
  // alternate read clock; a half period of 41 matches the input clock rate
  always @(negedge i_mclk) begin
    if (alt_run) begin
      alt_cnt <= (alt_cnt >= alt_half - 1) ? 0 : alt_cnt + 1;
      if (alt_cnt >= alt_half - 1) alt_clk <= ~alt_clk;
    end
  end
  task automatic cycles(input int n);
    repeat (n) @(negedge i_mclk);
  endtask
  task automatic print_verdict();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_step(input logic [STEP_W-1:0] got, input logic [STEP_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // bounded wait for the slip flag; running out ends the run
  task automatic wait_flag(input int lim);
    int t;
    t = 0;
    while (o_slip_error_flag !== 1'b1 && t < lim) begin
      @(negedge i_mclk);
      t++;
    end
    check_bit(o_slip_error_flag, 1'b1);
    if (t == lim) print_verdict();
  endtask
  // data out sampled at six output clock rises
  task automatic check_stream(input logic exp);
    int n;
    int t;
    logic prev;
    n = 0;
    prev = link.output_clock;
    for (t = 0; t < 4000 && n < 6; t++) begin
      @(negedge i_mclk);
      if (link.output_clock && !prev) begin
        n++;
        check_bit(link.data_out, exp);
      end
      prev = link.output_clock;
    end
    if (n < 6) begin
      fails++;
      print_verdict();
    end
  endtask
  // restart the source: pointer reset pulse, then flag clear pulse
  task automatic restart_source();
    src_reset = 1'b1;
    cycles(2);
    src_reset = 1'b0;
    cycles(12);
    check_bit(link.output_clock, 1'b0);
    check_bit(link.oscillator_monitor_out, 1'b0);
    cycles(60);
    check_bit(o_slip_error_flag, 1'b0);
  endtask
  initial begin
    dev_reset = 1'b1;
    src_reset = 1'b1;
    bit_in = 1'b1;
    use_alt = 1'b0;
    alt_clk = 1'b0;
    alt_run = 1'b0;
    alt_cnt = 0;
    alt_half = 41;
    fails = 0;
    total_checks = 0;
    cycles(2);
    dev_reset = 1'b0;
    check_step(o_osc_step, STEP_MID);
    restart_source();
    $display("test startup done");
    // oscillator read: runs of ones then zeros must pass unchanged
    cycles(3300);
    check_stream(1'b1);
    bit_in = 1'b0;
    cycles(3300);
    check_stream(1'b0);
    check_bit(o_slip_error_flag, 1'b0);
    $display("test oscillator read done");
    // alternate clock at the input rate, then stopped to force an overflow
    bit_in = 1'b1;
    use_alt = 1'b1;
    alt_run = 1'b1;
    cycles(2500);
    check_stream(1'b1);
    check_bit(o_slip_error_flag, 1'b0);
    alt_run = 1'b0;
    cycles(20);
    check_bit(link.output_clock, alt_clk);
    wait_flag(3000);
    cycles(500);
    check_bit(o_slip_error_flag, 1'b1);
    $display("test overflow done");
    // clear, then read twice as fast as writes so the read side overtakes
    restart_source();
    alt_half = 20;
    alt_run = 1'b1;
    wait_flag(3000);
    $display("test underflow done");
    print_verdict();
  end
endmodule
